// ### rtl/bsx_bank.sv
`timescale 1ns/1ps
`default_nettype none

module bsx_bank (
    input wire logic clock,
    input wire logic reset,
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [4:0] raddr,
    output logic [7:0] rdata
);

    logic [7:0] mem [0:bsx_pkg::BANK_DEPTH-1];

    generate
        for (genvar i = 0; i < bsx_pkg::BANK_DEPTH; i++) begin : g_entry
            always_ff @(posedge clock) begin
                if (we && waddr == 5'(i)) begin
                    mem[i] <= wdata;
                end
            end
        end
    endgenerate

    // Write-first, so a load right behind a store sees the new value
    always_ff @(posedge clock) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (we && waddr == raddr) begin
            rdata <= wdata;
        end else if (raddr <= bsx_pkg::BANK_LAST) begin
            rdata <= mem[raddr];
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule

`default_nettype wire

// ### rtl/bsx_exec.sv
// Function
// - Register subtract: R plus inverted W plus carry
// - Destination bit picks working register or R
// - Zero result without borrow sets carry, zero
// - Underflow clears carry; clear carry subtracts one
// - Immediate subtract always lands in working register
// - Store copies working register into bank entry
// - Load copies bank entry into working register
// - Sleep pulses watchdog clear for one cycle
// - Sleep sets timeout flag, clears powerdown, halts
`timescale 1ns/1ps
`default_nettype none

module bsx_exec (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic INSTR_VALID,
    input wire bsx_pkg::bsx_instr_s INSTR,
    output logic INSTR_READY,
    output logic [6:0] FILE_RADDR,
    input wire logic [7:0] FILE_RDATA,
    output bsx_pkg::bsx_file_s FILE_WR,
    output logic [7:0] WORKING_REG,
    output bsx_pkg::bsx_flags_s FLAGS,
    output logic HALT,
    output logic WATCHDOG_CLEAR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    logic accept;
    logic exec_valid;
    bsx_pkg::bsx_instr_s exec_instr;
    logic [7:0] bank_rdata;
    logic is_sub_reg;
    logic is_sub_imm;
    logic is_sub;
    logic is_store;
    logic is_load;
    logic is_sleep;
    logic bank_hit;
    logic [7:0] operand_a;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [7:0] result;
    logic apb_access;
    logic apb_commit;
    logic apb_mapped;
    logic wr_work;
    logic wr_status;
    logic wr_control;
    logic [31:0] next_prdata;

    assign accept = INSTR_VALID && INSTR_READY;

    // Decode stage: capture instruction, present operand address
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            exec_valid <= 1'b0;
            exec_instr <= '0;
        end else begin
            exec_valid <= accept;
            if (accept) begin
                exec_instr <= INSTR;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            FILE_RADDR <= 7'h00;
        end else if (accept) begin
            FILE_RADDR <= INSTR.operand[6:0];
        end
    end

    // Execute stage decode
    always_comb begin
        is_sub_reg = 1'b0;
        is_sub_imm = 1'b0;
        is_store = 1'b0;
        is_load = 1'b0;
        is_sleep = 1'b0;
        if (exec_valid) begin
            unique case (exec_instr.op)
                bsx_pkg::OP_SUB_REG: is_sub_reg = 1'b1;
                bsx_pkg::OP_SUB_IMM: is_sub_imm = 1'b1;
                bsx_pkg::OP_STORE_BANK: is_store = 1'b1;
                bsx_pkg::OP_LOAD_BANK: is_load = 1'b1;
                bsx_pkg::OP_SLEEP: is_sleep = 1'b1;
                default: is_sleep = 1'b0;
            endcase
        end
    end

    assign is_sub = is_sub_reg || is_sub_imm;
    assign bank_hit = exec_instr.operand[7:5] == 3'h0 && exec_instr.operand[4:0] <= bsx_pkg::BANK_LAST;

    // Borrow subtract as an add of the complement plus carry
    assign operand_a = is_sub_reg ? FILE_RDATA : exec_instr.operand;
    assign sum9 = {1'b0, operand_a} + {1'b0, ~WORKING_REG} + {8'h00, FLAGS.carry};
    assign nib5 = {1'b0, operand_a[3:0]} + {1'b0, ~WORKING_REG[3:0]} + {4'h0, FLAGS.carry};
    assign result = sum9[7:0];

    bsx_bank u_bank (
        .clock(CLOCK),
        .reset(RESET),
        .we(is_store && bank_hit),
        .waddr(exec_instr.operand[4:0]),
        .wdata(WORKING_REG),
        .raddr(INSTR.operand[4:0]),
        .rdata(bank_rdata)
    );

    // Register bus
    assign apb_access = PSEL && PENABLE;
    assign apb_commit = apb_access && PREADY;
    assign apb_mapped = PADDR == bsx_pkg::ADDR_WORK || PADDR == bsx_pkg::ADDR_STATUS
        || PADDR == bsx_pkg::ADDR_CONTROL;
    assign wr_work = apb_commit && PWRITE && PADDR == bsx_pkg::ADDR_WORK;
    assign wr_status = apb_commit && PWRITE && PADDR == bsx_pkg::ADDR_STATUS;
    assign wr_control = apb_commit && PWRITE && PADDR == bsx_pkg::ADDR_CONTROL;

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (PADDR == bsx_pkg::ADDR_WORK) begin
            next_prdata = {24'h00_0000, WORKING_REG};
        end else if (PADDR == bsx_pkg::ADDR_STATUS) begin
            next_prdata = {27'h000_0000, FLAGS};
        end else if (PADDR == bsx_pkg::ADDR_CONTROL) begin
            next_prdata = {31'h0000_0000, HALT};
        end
    end

    // One wait state: ready rises in the second access cycle
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= bsx_pkg::PRDATA_RESET;
        end else begin
            PREADY <= apb_access && !PREADY;
            if (apb_access && !PREADY) begin
                PSLVERR <= !apb_mapped;
                PRDATA <= PWRITE ? 32'h0000_0000 : next_prdata;
            end else begin
                PSLVERR <= 1'b0;
                PRDATA <= 32'h0000_0000;
            end
        end
    end

    // Working register: instructions win over the bus
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            WORKING_REG <= bsx_pkg::WORK_RESET;
        end else if ((is_sub_reg && !exec_instr.dest) || is_sub_imm) begin
            WORKING_REG <= result;
        end else if (is_load) begin
            WORKING_REG <= bank_hit ? bank_rdata : 8'h00;
        end else if (wr_work) begin
            WORKING_REG <= PWDATA[7:0];
        end
    end

    // Write back into the register file
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            FILE_WR <= '0;
        end else begin
            FILE_WR.we <= is_sub_reg && exec_instr.dest;
            FILE_WR.addr <= exec_instr.operand[6:0];
            FILE_WR.wdata <= result;
        end
    end

    // Status flags
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            FLAGS <= bsx_pkg::STATUS_RESET;
        end else if (is_sub) begin
            FLAGS.carry <= sum9[8];
            FLAGS.nibble <= nib5[4];
            FLAGS.zero <= result == 8'h00;
        end else if (is_sleep) begin
            FLAGS.to_n <= 1'b1;
            FLAGS.pd_n <= 1'b0;
        end else if (wr_status) begin
            FLAGS <= PWDATA[4:0];
        end
    end

    // Sleep: watchdog clear pulse and halt
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            WATCHDOG_CLEAR <= 1'b0;
        end else begin
            WATCHDOG_CLEAR <= is_sleep;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            HALT <= 1'b0;
        end else if (is_sleep) begin
            HALT <= 1'b1;
        end else if (wr_control && PWDATA[bsx_pkg::CTRL_HALT]) begin
            HALT <= 1'b0;
        end
    end

    // Stop taking instructions as soon as a sleep is taken
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            INSTR_READY <= 1'b1;
        end else if (accept && INSTR.op == bsx_pkg::OP_SLEEP) begin
            INSTR_READY <= 1'b0;
        end else if (HALT && !is_sleep && wr_control && PWDATA[bsx_pkg::CTRL_HALT]) begin
            INSTR_READY <= 1'b1;
        end
    end

    // Checks
    logic [8:0] need9;
    logic [7:0] diff8;
    logic [4:0] need5;

    assign need9 = {1'b0, WORKING_REG} + {8'h00, !FLAGS.carry};
    assign diff8 = operand_a - WORKING_REG - {7'h00, !FLAGS.carry};
    assign need5 = {1'b0, WORKING_REG[3:0]} + {4'h0, !FLAGS.carry};

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    sequence sleep_seq;
        exec_valid && exec_instr.op == bsx_pkg::OP_SLEEP;
    endsequence

    sequence store_seq;
        is_store && bank_hit;
    endsequence

    sub_reg_value_a: assert property (
        is_sub_reg && !exec_instr.dest |=> WORKING_REG == $past(diff8))
        else $error("register subtract gave a wrong working value");

    dest_route_a: assert property (
        is_sub_reg && exec_instr.dest && !wr_work
            |=> FILE_WR.we && FILE_WR.wdata == $past(diff8)
            && WORKING_REG == $past(WORKING_REG))
        else $error("register subtract with dest one misrouted");

    zero_no_borrow_a: assert property (
        is_sub && {1'b0, operand_a} == need9 |=> FLAGS.carry && FLAGS.zero)
        else $error("zero result without borrow left flags wrong");

    borrow_clear_a: assert property (
        is_sub && {1'b0, operand_a} < need9 |=> !FLAGS.carry)
        else $error("underflow did not clear carry");

    imm_value_a: assert property (
        is_sub_imm |=> WORKING_REG == $past(diff8) && !FILE_WR.we)
        else $error("immediate subtract result not in working register");

    store_quiet_a: assert property (
        store_seq ##0 (!wr_work && !wr_status)
            |=> FLAGS == $past(FLAGS) && WORKING_REG == $past(WORKING_REG))
        else $error("bank store changed flags or working register");

    store_load_a: assert property (
        store_seq ##0 (accept && INSTR.op == bsx_pkg::OP_LOAD_BANK
            && INSTR.operand == exec_instr.operand) |=> ##1 WORKING_REG == $past(WORKING_REG, 2))
        else $error("load right after store missed the stored value");

    bank_load_a: assert property (
        is_load && bank_hit && !wr_status
            |=> WORKING_REG == $past(bank_rdata) && FLAGS == $past(FLAGS))
        else $error("bank load wrong");

    sleep_clear_a: assert property (
        sleep_seq |=> WATCHDOG_CLEAR ##1 !WATCHDOG_CLEAR)
        else $error("watchdog clear pulse wrong after sleep");

    sleep_flags_a: assert property (
        sleep_seq |=> FLAGS.to_n && !FLAGS.pd_n && HALT && !INSTR_READY)
        else $error("sleep did not set power flags and halt");

    nibble_carry_a: assert property (
        is_sub |=> FLAGS.nibble == ($past({1'b0, operand_a[3:0]}) >= $past(need5)))
        else $error("nibble carry wrong");

    nonzero_clear_a: assert property (
        is_sub && diff8 != 8'h00 |=> !FLAGS.zero)
        else $error("nonzero result left zero flag set");

endmodule

`default_nettype wire

// ### rtl/bsx_pkg.sv
package bsx_pkg;

    // Bank geometry
    localparam int BANK_DEPTH = 22;
    localparam logic [4:0] BANK_LAST = 5'h15;

    // Register bus offsets (byte addresses)
    localparam logic [7:0] ADDR_WORK = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;

    // Status register bit positions
    localparam int STAT_CARRY = 0;
    localparam int STAT_NIBBLE = 1;
    localparam int STAT_ZERO = 2;
    localparam int STAT_PD_N = 3;
    localparam int STAT_TO_N = 4;

    // Control register bit positions
    localparam int CTRL_HALT = 0;

    // Values after reset
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [4:0] STATUS_RESET = 5'h18;
    localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

    // Instruction latency through the execute stage
    localparam int EXEC_CYCLES = 1;

    typedef enum logic [2:0] {
        OP_SUB_REG,
        OP_SUB_IMM,
        OP_STORE_BANK,
        OP_LOAD_BANK,
        OP_SLEEP
    } bsx_op_e;

    typedef struct packed {
        bsx_op_e op;
        logic dest;
        logic [7:0] operand;
    } bsx_instr_s;

    typedef struct packed {
        logic to_n;
        logic pd_n;
        logic zero;
        logic nibble;
        logic carry;
    } bsx_flags_s;

    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] wdata;
    } bsx_file_s;

endpackage

// ### test/bsx_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module bsx_exec_tb_top;
    typedef struct packed {
        bsx_pkg::bsx_op_e op;
        logic d;
        logic [7:0] rv;
        logic [7:0] w;
        logic c;
        logic [7:0] res;
        logic [2:0] znc;
    } bsx_row_s;

    logic clock, reset, ivalid, psel, penable, pwrite, iready, halt, wclr, pready, pslverr;
    bsx_pkg::bsx_instr_s instr;
    logic [6:0] raddr;
    logic [7:0] rdata, work, paddr;
    bsx_pkg::bsx_file_s fwr;
    bsx_pkg::bsx_flags_s flags;
    logic [31:0] pwdata, prdata, rd;
    logic err;
    int err_count, num_checks;

    // Worked examples with carry in 0 and 1, plus a carry without nibble carry
    bsx_row_s rows [8] = '{
        '{bsx_pkg::OP_SUB_REG, 1'b1, 8'h05, 8'h06, 1'b0, 8'hFE, 3'h0},
        '{bsx_pkg::OP_SUB_REG, 1'b1, 8'h05, 8'h06, 1'b1, 8'hFF, 3'h0},
        '{bsx_pkg::OP_SUB_REG, 1'b1, 8'h06, 8'h05, 1'b0, 8'h00, 3'h7},
        '{bsx_pkg::OP_SUB_REG, 1'b1, 8'h06, 8'h05, 1'b1, 8'h01, 3'h3},
        '{bsx_pkg::OP_SUB_REG, 1'b0, 8'h10, 8'h01, 1'b1, 8'h0F, 3'h1},
        '{bsx_pkg::OP_SUB_IMM, 1'b1, 8'h05, 8'h06, 1'b0, 8'hFE, 3'h0},
        '{bsx_pkg::OP_SUB_IMM, 1'b0, 8'h06, 8'h05, 1'b0, 8'h00, 3'h7},
        '{bsx_pkg::OP_SUB_IMM, 1'b0, 8'h06, 8'h05, 1'b1, 8'h01, 3'h3}
    };

    bsx_exec uut (
        .CLOCK(clock), .RESET(reset), .INSTR_VALID(ivalid), .INSTR(instr),
        .INSTR_READY(iready), .FILE_RADDR(raddr), .FILE_RDATA(rdata), .FILE_WR(fwr),
        .WORKING_REG(work), .FLAGS(flags), .HALT(halt), .WATCHDOG_CLEAR(wclr),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        // Hold the access until ready is sampled high at a rising edge
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Returns in the cycle where the results of the instruction are visible
    task automatic issue(input bsx_pkg::bsx_op_e op, input logic d, input logic [7:0] opd,
            input logic [7:0] rv);
        @(posedge clock);
        ivalid <= 1'b1;
        instr <= '{op, d, opd};
        rdata <= rv;
        @(posedge clock);
        ivalid <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(3000 * 100);
        err_count++;
        report_and_stop();
    end

    initial begin
        reset = 1'b1;
        {ivalid, psel, penable, pwrite} = 4'h0;
        instr = '0;
        rdata = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1;
        chk("reset flags", 32'h18, flags);
        chk("reset work", 32'h0, work);
        chk("reset ready", 32'h1, iready);
        chk("reset halt", 32'h0, halt);
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1'b1, bsx_pkg::ADDR_WORK, {24'h0, rows[i].w});
            apb(1'b1, bsx_pkg::ADDR_STATUS, {27'h0, 4'hC, rows[i].c});
            issue(rows[i].op, rows[i].d,
                (rows[i].op == bsx_pkg::OP_SUB_IMM) ? rows[i].rv : 8'h20, rows[i].rv);
            if (rows[i].op == bsx_pkg::OP_SUB_REG && rows[i].d) begin
                chk("file we", 32'h1, fwr.we);
                chk("file addr", 32'h20, fwr.addr);
                chk("file raddr", 32'h20, raddr);
                chk("file data", rows[i].res, fwr.wdata);
            end else begin
                chk("file we", 32'h0, fwr.we);
                chk("work", rows[i].res, work);
            end
            chk("flags", {2'b11, rows[i].znc}, flags);
            $display("test row %0d done", i);
        end
        apb(1'b1, bsx_pkg::ADDR_STATUS, 32'h1F);
        apb(1'b1, bsx_pkg::ADDR_WORK, 32'hAA);
        issue(bsx_pkg::OP_STORE_BANK, 1'b0, 8'h15, 8'h00);
        chk("store flags", 32'h1F, flags);
        apb(1'b1, bsx_pkg::ADDR_WORK, 32'h00);
        issue(bsx_pkg::OP_LOAD_BANK, 1'b0, 8'h15, 8'h00);
        chk("load work", 32'hAA, work);
        chk("load flags", 32'h1F, flags);
        issue(bsx_pkg::OP_STORE_BANK, 1'b0, 8'h16, 8'h00);
        issue(bsx_pkg::OP_LOAD_BANK, 1'b0, 8'h16, 8'h00);
        chk("load past end", 32'h00, work);
        apb(1'b1, bsx_pkg::ADDR_WORK, 32'h5A);
        @(posedge clock);
        ivalid <= 1'b1;
        instr <= '{bsx_pkg::OP_STORE_BANK, 1'b0, 8'h03};
        @(posedge clock);
        instr <= '{bsx_pkg::OP_LOAD_BANK, 1'b0, 8'h03};
        @(posedge clock);
        ivalid <= 1'b0;
        @(posedge clock);
        #1;
        chk("store then load", 32'h5A, work);
        $display("test bank done");
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped err", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, bsx_pkg::ADDR_STATUS, 32'h08);
        issue(bsx_pkg::OP_SLEEP, 1'b0, 8'h00, 8'h00);
        chk("wd clear", 32'h1, wclr);
        chk("halt", 32'h1, halt);
        chk("sleep flags", 32'h10, flags);
        chk("ready in halt", 32'h0, iready);
        @(posedge clock);
        #1;
        chk("wd clear end", 32'h0, wclr);
        apb(1'b0, bsx_pkg::ADDR_CONTROL, 32'h0);
        chk("control halt", 32'h1, rd);
        apb(1'b1, bsx_pkg::ADDR_CONTROL, 32'h1);
        #1;
        chk("halt cleared", 32'h0, halt);
        chk("ready again", 32'h1, iready);
        $display("test sleep done");
        issue(bsx_pkg::bsx_op_e'(3'h5), 1'b1, 8'h20, 8'h33);
        chk("spare op work", 32'h5A, work);
        chk("spare op flags", 32'h10, flags);
        chk("spare op file we", 32'h0, fwr.we);
        chk("spare op ready", 32'h1, iready);
        $display("test spare op done");
        issue(bsx_pkg::OP_SLEEP, 1'b0, 8'h00, 8'h00);
        chk("halt before reset", 32'h1, halt);
        @(posedge clock);
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1;
        chk("rerun flags", 32'h18, flags);
        chk("rerun work", 32'h0, work);
        chk("rerun ready", 32'h1, iready);
        chk("rerun halt", 32'h0, halt);
        chk("rerun wd clear", 32'h0, wclr);
        chk("rerun file we", 32'h0, fwr.we);
        chk("rerun pready", 32'h0, pready);
        $display("test mid reset done");
        report_and_stop();
    end
endmodule

`default_nettype wire
